// ==== hdl/feedback_pkg.sv ====
package feedback_pkg;

  // Clock and bus geometry
  localparam int          CLK_MHZ     = 25;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_GEAR   = 8'h04;
  localparam logic [7:0]  ADDR_INDEX  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0c;
  localparam logic [7:0]  ADDR_CMDPOS = 8'h10;
  localparam logic [7:0]  ADDR_FBPOS  = 8'h14;

  // Control field positions
  localparam int          CTRL_FB_MODE_LSB  = 0;
  localparam int          CTRL_FB_NEG       = 2;
  localparam int          CTRL_CMD_MODE_LSB = 3;
  localparam int          CTRL_CMD_NEG      = 5;
  localparam int          CTRL_FOLDED       = 6;
  localparam int          CTRL_W            = 7;
  localparam int          GEAR_NUM_LSB      = 0;
  localparam int          GEAR_DEN_LSB      = 16;

  // Status field positions
  localparam int          STAT_SEQ_LSB  = 0;
  localparam int          STAT_FSTOP    = 4;
  localparam int          STAT_FB_BUSY  = 5;
  localparam int          STAT_FB_REV   = 6;

  // Values after reset
  localparam logic [6:0]  CTRL_RESET  = 7'h00;
  localparam logic [31:0] GEAR_RESET  = 32'h0001_0001;
  localparam logic [15:0] INDEX_RESET = 16'h0800;

  // Timing: sequence filter, host hold times, feedback pulse half period
  localparam int          FILTER_TIME_US     = 4000;
  localparam int          FILTER_CYCLES_DEF  = FILTER_TIME_US * CLK_MHZ;
  localparam int          FILTER_CNT_W       = 17;
  localparam int          SEQ_HOLD_MS        = 6;
  localparam int          FSTOP_HOLD_MS      = 10;
  localparam int          FB_HALF_NS         = 1000;
  localparam int          FB_HALF_CYCLES     = (FB_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int          CMD_RATE_OC_KPPS   = 200;
  localparam int          CMD_RATE_DIFF_KPPS = 500;
  localparam int          SEQ_W              = 4;

  // Pulse train encodings, shared by command input and feedback output
  typedef enum logic [1:0] {
    PM_QUAD      = 2'h0,
    PM_PULSE_DIR = 2'h1,
    PM_FWD_REV   = 2'h2
  } pulse_mode_t;

  // Feedback pulse generator states
  typedef enum logic [2:0] {
    FB_IDLE    = 3'b001,
    FB_ACTIVE  = 3'b010,
    FB_RECOVER = 3'b100
  } fb_state_t;

  // Command pulse receiver lines
  typedef struct packed {
    logic cmd_train_fwd_line;
    logic cmd_train_fwd_line_neg;
    logic cmd_train_second_line;
    logic cmd_train_second_line_neg;
  } cmd_lines_t;

  // Differential feedback driver lines
  typedef struct packed {
    logic feedback_phase_a_pos;
    logic feedback_phase_a_neg;
    logic feedback_phase_b_pos;
    logic feedback_phase_b_neg;
    logic feedback_index_pos;
    logic feedback_index_neg;
  } fb_lines_t;

  // Detected position quadrature from the encoder path
  typedef struct packed {
    logic a;
    logic b;
  } enc_lines_t;

  // Gear scaler state: remainder, queued input steps, output step flags
  typedef struct packed {
    logic signed [19:0] acc;
    logic signed [7:0]  pend;
    logic               up;
    logic               dn;
  } gear_t;

  // Quadrature step {fwd, rev}; forward when A leads B
  function automatic logic [1:0] quad_step(input logic pa, input logic pb,
                                           input logic ca, input logic cb);
    logic [3:0] s;
    s = {pa, pb, ca, cb};
    if (s == 4'h2 || s == 4'hb || s == 4'hd || s == 4'h4) begin
      quad_step = 2'b10;
    end else if (s == 4'h1 || s == 4'h7 || s == 4'he || s == 4'h8) begin
      quad_step = 2'b01;
    end else begin
      quad_step = 2'b00;
    end
  endfunction

  // One cycle of ratio scaling: each input step adds mul, each div emits a step
  function automatic gear_t gear_advance(input gear_t s, input logic [15:0] mul,
                                         input logic [15:0] div, input logic inc,
                                         input logic dec, input logic hold);
    gear_t              r;
    logic signed [19:0] m;
    logic signed [19:0] d;
    r    = s;
    r.up = 1'b0;
    r.dn = 1'b0;
    m    = $signed({4'h0, mul});
    d    = (div == 16'h0000) ? 20'sd1 : $signed({4'h0, div});
    if (inc && !dec && s.pend != 8'sd127) begin
      r.pend = s.pend + 8'sd1;
    end else if (dec && !inc && s.pend != -8'sd127) begin
      r.pend = s.pend - 8'sd1;
    end
    if (hold) begin
      r.acc = s.acc;
    end else if (s.acc >= d) begin
      r.acc = s.acc - d;
      r.up  = 1'b1;
    end else if (s.acc <= -d) begin
      r.acc = s.acc + d;
      r.dn  = 1'b1;
    end else if (r.pend > 8'sd0) begin
      r.acc  = s.acc + m;
      r.pend = r.pend - 8'sd1;
    end else if (r.pend < 8'sd0) begin
      r.acc  = s.acc - m;
      r.pend = r.pend + 8'sd1;
    end
    return r;
  endfunction

endpackage

// ==== hdl/seq_filter.sv ====
module seq_filter #(
  parameter int                WIDTH = 4,
  parameter int                CNT_W = 17,
  parameter logic [CNT_W-1:0]  LIMIT = 17'd100000
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Raw and qualified levels
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] filt
);

  logic [CNT_W-1:0] cnt      [WIDTH];  // Per-bit stability counters
  logic [CNT_W-1:0] next_cnt [WIDTH];
  logic [WIDTH-1:0] next_filt;

  // A bit follows only after the raw level differed for LIMIT cycles
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_filt[i] = filt[i];
      next_cnt[i]  = '0;
      if (raw[i] != filt[i]) begin
        if (cnt[i] >= LIMIT - 1'b1) begin
          next_filt[i] = raw[i];
        end else begin
          next_cnt[i] = cnt[i] + 1'b1;
        end
      end
    end
  end

  // Register counters and levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt <= '0;
      for (int i = 0; i < WIDTH; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      filt <= next_filt;
      for (int i = 0; i < WIDTH; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

endmodule // seq_filter

// ==== hdl/cmd_pulse_decode.sv ====
module cmd_pulse_decode (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // Receiver lines and settings
  input  wire feedback_pkg::cmd_lines_t  lines,
  input  wire feedback_pkg::pulse_mode_t mode,
  input  wire logic                      negative,
  // Decoded one-cycle steps
  output logic                           step_fwd,
  output logic                           step_rev
);
  import feedback_pkg::*;

  logic a_lvl, b_lvl;             // Held differential levels
  logic pa, pb;                   // Previous corrected levels
  logic next_a_lvl, next_b_lvl;
  logic ca, cb;
  logic next_fwd, next_rev;

  // Decode per mode; lines sampled directly, never filtered
  always_comb begin
    // A pair with equal legs is not a valid differential state: keep level
    next_a_lvl = (lines.cmd_train_fwd_line != lines.cmd_train_fwd_line_neg) ?
                 lines.cmd_train_fwd_line : a_lvl;
    next_b_lvl = (lines.cmd_train_second_line != lines.cmd_train_second_line_neg) ?
                 lines.cmd_train_second_line : b_lvl;
    ca = a_lvl ^ negative;
    cb = b_lvl ^ negative;
    next_fwd = 1'b0;
    next_rev = 1'b0;
    case (mode)
      PM_PULSE_DIR: begin
        // Train on the first pair, direction level on the second
        next_fwd = ca & ~pa & ~cb;
        next_rev = ca & ~pa & cb;
      end
      PM_FWD_REV: begin
        // Separate forward and reverse trains
        next_fwd = ca & ~pa;
        next_rev = cb & ~pb;
      end
      default: begin
        {next_fwd, next_rev} = quad_step(pa, pb, ca, cb);
      end
    endcase
  end

  // Register levels and steps; changing polarity may cause one stray step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_lvl    <= 1'b0;
      b_lvl    <= 1'b0;
      pa       <= 1'b0;
      pb       <= 1'b0;
      step_fwd <= 1'b0;
      step_rev <= 1'b0;
    end else begin
      a_lvl    <= next_a_lvl;
      b_lvl    <= next_b_lvl;
      pa       <= ca;
      pb       <= cb;
      step_fwd <= next_fwd;
      step_rev <= next_rev;
    end
  end

endmodule // cmd_pulse_decode

// ==== hdl/feedback_pulse_and_input_qualify.sv ====
//Contract
// - Position leaves as differential A, B, Z
// - Feedback format: quadrature, pulse-dir, fwd/rev
// - Feedback polarity positive or negative selectable
// - Feedback scaled by the inverse of the command gear ratio
// - Forward pulse moves actuator negative, folded inverts
// - Forward means counter-clockwise from load side
// - Sequence inputs filtered against chattering
// - Forced stop, command lines bypass the filter
// - Command formats and polarity, 200/500 kpps
// - Electronic gear sets movement per command pulse
module feedback_pulse_and_input_qualify #(
  parameter logic [16:0] FILTER_CYCLES = 17'd100000  // Sequence filter length
) (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Host side pins
  input  wire feedback_pkg::cmd_lines_t   cmd_lines,
  input  wire logic                       external_forced_stop,
  input  wire logic [3:0]                 seq_raw,
  output feedback_pkg::fb_lines_t         fb_lines,
  // Position detection path
  input  wire feedback_pkg::enc_lines_t   enc,
  // Toward the motion loop
  output logic                            actuator_step_pos,
  output logic                            actuator_step_neg,
  output logic                            forced_stop,
  output logic [3:0]                      seq_filtered
);
  import feedback_pkg::*;

  // Configuration registers
  logic [6:0]         ctrl, next_ctrl;
  logic [31:0]        gear, next_gear;
  logic [15:0]        index_len, next_index_len;
  logic [31:0]        next_prdata;
  logic               next_pready, next_pslverr;
  logic               access, wr_en;

  // Decoded settings
  pulse_mode_t        fb_mode, cmd_mode;
  logic               fb_neg, cmd_neg, folded;
  logic [15:0]        gear_num, gear_den;

  // Command path state
  logic               cmd_fwd, cmd_rev;
  gear_t              cmd_gear, next_cmd_gear;
  logic signed [31:0] cmd_pos, next_cmd_pos;
  logic               next_act_pos, next_act_neg;

  // Feedback path state
  logic               enc_pa, enc_pb;
  logic [1:0]         enc_step;
  gear_t              fb_gear, next_fb_gear;
  fb_state_t          fb_state, next_fb_state;
  logic [4:0]         fb_timer, next_fb_timer;
  logic [1:0]         qph, next_qph;
  logic               fb_rev, next_fb_rev;
  logic signed [31:0] fb_pos, next_fb_pos;
  logic [15:0]        idx, next_idx;
  logic [15:0]        idx_len;
  fb_lines_t          next_fb_lines;
  logic               la, lb, lz;

  // Field extraction
  assign fb_mode  = pulse_mode_t'(ctrl[CTRL_FB_MODE_LSB +: 2]);
  assign fb_neg   = ctrl[CTRL_FB_NEG];
  assign cmd_mode = pulse_mode_t'(ctrl[CTRL_CMD_MODE_LSB +: 2]);
  assign cmd_neg  = ctrl[CTRL_CMD_NEG];
  assign folded   = ctrl[CTRL_FOLDED];
  assign gear_num = gear[GEAR_NUM_LSB +: 16];
  assign gear_den = gear[GEAR_DEN_LSB +: 16];
  assign idx_len  = (index_len == 16'h0000) ? 16'h0001 : index_len;

  // Write commits on the edge where pready is seen high
  assign access = psel & penable & pready;
  assign wr_en  = access & pwrite;

  // Register file: one wait state, registered read data
  always_comb begin
    next_ctrl      = ctrl;
    next_gear      = gear;
    next_index_len = index_len;
    next_pready    = psel & penable & ~pready;
    next_prdata    = 32'h0000_0000;
    next_pslverr   = 1'b0;
    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        next_ctrl = pwdata[CTRL_W-1:0];
      end else if (paddr == ADDR_GEAR) begin
        next_gear = pwdata;
      end else if (paddr == ADDR_INDEX) begin
        next_index_len = pwdata[15:0];
      end
    end
    if (psel & penable & ~pready) begin
      if (paddr == ADDR_CTRL) begin
        next_prdata = {25'h0, ctrl};
      end else if (paddr == ADDR_GEAR) begin
        next_prdata = gear;
      end else if (paddr == ADDR_INDEX) begin
        next_prdata = {16'h0, index_len};
      end else if (paddr == ADDR_STATUS) begin
        next_prdata = {25'h0, fb_rev, (fb_state != FB_IDLE), forced_stop, seq_filtered};
      end else if (paddr == ADDR_CMDPOS) begin
        next_prdata = cmd_pos;
      end else if (paddr == ADDR_FBPOS) begin
        next_prdata = fb_pos;
      end else begin
        // Unmapped address answers with an error and zero data
        next_pslverr = 1'b1;
      end
    end
  end

  // Register file flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl      <= CTRL_RESET;
      gear      <= GEAR_RESET;
      index_len <= INDEX_RESET;
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      gear      <= next_gear;
      index_len <= next_index_len;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  // Command receiver, sampled without the chattering filter
  cmd_pulse_decode u_cmd_decode (
    .pclk     (pclk),
    .presetn  (presetn),
    .lines    (cmd_lines),
    .mode     (cmd_mode),
    .negative (cmd_neg),
    .step_fwd (cmd_fwd),
    .step_rev (cmd_rev)
  );

  // Slow sequence inputs through the time-constant filter
  seq_filter #(
    .WIDTH (SEQ_W),
    .CNT_W (FILTER_CNT_W),
    .LIMIT (FILTER_CYCLES)
  ) u_seq_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (seq_raw),
    .filt    (seq_filtered)
  );

  // Command gear: num/den motor units per pulse, then actuator direction
  always_comb begin
    next_cmd_gear = gear_advance(cmd_gear, gear_num, gear_den, cmd_fwd, cmd_rev,
                                 1'b0);
    next_cmd_pos  = cmd_pos;
    if (cmd_gear.up) begin
      next_cmd_pos = cmd_pos + 32'sd1;
    end else if (cmd_gear.dn) begin
      next_cmd_pos = cmd_pos - 32'sd1;
    end
    // Motor forward drives the actuator negative unless the motor is folded
    next_act_neg = folded ? cmd_gear.dn : cmd_gear.up;
    next_act_pos = folded ? cmd_gear.up : cmd_gear.dn;
  end

  // Command path flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_gear          <= '0;
      cmd_pos           <= 32'sd0;
      actuator_step_pos <= 1'b0;
      actuator_step_neg <= 1'b0;
      forced_stop       <= 1'b0;
    end else begin
      cmd_gear          <= next_cmd_gear;
      cmd_pos           <= next_cmd_pos;
      actuator_step_pos <= next_act_pos;
      actuator_step_neg <= next_act_neg;
      forced_stop       <= external_forced_stop;
    end
  end

  // Encoder steps scaled by the inverse ratio into feedback steps
  always_comb begin
    enc_step      = quad_step(enc_pa, enc_pb, enc.a, enc.b);
    // Scaler stalls while a feedback step is in flight so none is dropped
    next_fb_gear  = gear_advance(fb_gear, gear_den, gear_num, enc_step[1], enc_step[0],
                                 (fb_state != FB_IDLE) | fb_gear.up | fb_gear.dn);
    next_fb_state = fb_state;
    next_fb_timer = fb_timer;
    next_qph      = qph;
    next_fb_rev   = fb_rev;
    next_fb_pos   = fb_pos;
    next_idx      = idx;
    case (fb_state)
      FB_IDLE: begin
        if (fb_gear.up | fb_gear.dn) begin
          next_fb_rev   = fb_gear.dn;
          next_qph      = fb_gear.dn ? qph - 2'd1 : qph + 2'd1;
          next_fb_pos   = fb_gear.dn ? fb_pos - 32'sd1 : fb_pos + 32'sd1;
          if (fb_gear.dn) begin
            next_idx = (idx == 16'h0000) ? idx_len - 16'h0001 : idx - 16'h0001;
          end else begin
            next_idx = (idx >= idx_len - 16'h0001) ? 16'h0000 : idx + 16'h0001;
          end
          next_fb_timer = 5'(FB_HALF_CYCLES - 1);
          next_fb_state = FB_ACTIVE;
        end
      end
      FB_ACTIVE: begin
        // Pulse high half period
        if (fb_timer == 5'd0) begin
          next_fb_timer = 5'(FB_HALF_CYCLES - 1);
          next_fb_state = FB_RECOVER;
        end else begin
          next_fb_timer = fb_timer - 5'd1;
        end
      end
      FB_RECOVER: begin
        // Pulse low half period bounds the output rate
        if (fb_timer == 5'd0) begin
          next_fb_state = FB_IDLE;
        end else begin
          next_fb_timer = fb_timer - 5'd1;
        end
      end
      default: begin
        next_fb_state = FB_IDLE;
      end
    endcase
  end

  // Line encoding from the registered generator state
  always_comb begin
    case (fb_mode)
      PM_PULSE_DIR: begin
        la = (fb_state == FB_ACTIVE);
        lb = fb_rev;
      end
      PM_FWD_REV: begin
        la = (fb_state == FB_ACTIVE) & ~fb_rev;
        lb = (fb_state == FB_ACTIVE) & fb_rev;
      end
      default: begin
        la = qph[1];
        lb = qph[1] ^ qph[0];
      end
    endcase
    lz = (idx == 16'h0000);
    next_fb_lines.feedback_phase_a_pos = la ^ fb_neg;
    next_fb_lines.feedback_phase_a_neg = ~(la ^ fb_neg);
    next_fb_lines.feedback_phase_b_pos = lb ^ fb_neg;
    next_fb_lines.feedback_phase_b_neg = ~(lb ^ fb_neg);
    next_fb_lines.feedback_index_pos   = lz ^ fb_neg;
    next_fb_lines.feedback_index_neg   = ~(lz ^ fb_neg);
  end

  // Feedback path flops; lines come straight from here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_pa   <= 1'b0;
      enc_pb   <= 1'b0;
      fb_gear  <= '0;
      fb_state <= FB_IDLE;
      fb_timer <= 5'd0;
      qph      <= 2'd0;
      fb_rev   <= 1'b0;
      fb_pos   <= 32'sd0;
      idx      <= 16'h0000;
      fb_lines <= 6'b01_01_01;
    end else begin
      enc_pa   <= enc.a;
      enc_pb   <= enc.b;
      fb_gear  <= next_fb_gear;
      fb_state <= next_fb_state;
      fb_timer <= next_fb_timer;
      qph      <= next_qph;
      fb_rev   <= next_fb_rev;
      fb_pos   <= next_fb_pos;
      idx      <= next_idx;
      fb_lines <= next_fb_lines;
    end
  end

endmodule // feedback_pulse_and_input_qualify

// ==== sim/feedback_checker.sv ====
module feedback_checker #(
  parameter logic [16:0] FILTER_CYCLES = 17'd100000  // Filter length
) (
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // Bus handshake
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pready,
  // Host side pins
  input wire logic                      external_forced_stop,
  input wire logic [3:0]                seq_raw,
  input wire feedback_pkg::fb_lines_t   fb_lines,
  // Motion side
  input wire logic                      actuator_step_pos,
  input wire logic                      actuator_step_neg,
  input wire logic                      forced_stop,
  input wire logic [3:0]                seq_filtered
);
  import feedback_pkg::*;
  logic [3:0]  raw_q;         // Raw levels one edge ago
  logic [16:0] raw_age, next_raw_age;  // Edges since raw last moved
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Age saturates so long idle spells never wrap
  always_comb begin
    next_raw_age = (seq_raw != raw_q) ? 17'h0 : (&raw_age ? raw_age : raw_age + 17'h1);
  end
  // Age registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_q   <= 4'h0;
      raw_age <= 17'h0;
    end else begin
      raw_q   <= seq_raw;
      raw_age <= next_raw_age;
    end
  end
  AST_A_COMPL: assert property (fb_lines.feedback_phase_a_neg == !fb_lines.feedback_phase_a_pos)
    else $error("phase A legs not complementary");
  AST_B_COMPL: assert property (fb_lines.feedback_phase_b_neg != fb_lines.feedback_phase_b_pos)
    else $error("phase B legs not complementary");
  AST_Z_COMPL: assert property (fb_lines.feedback_index_neg ^ fb_lines.feedback_index_pos)
    else $error("index legs not complementary");
  AST_FSTOP: assert property ($past(presetn) |-> forced_stop == $past(external_forced_stop))
    else $error("forced stop not passed within one cycle");
  AST_STEP_EXCL: assert property (!(actuator_step_pos && actuator_step_neg))
    else $error("both actuator directions at once");
  AST_SEQ_FILT: assert property ($changed(seq_filtered) |-> raw_age >= FILTER_CYCLES - 17'd1)
    else $error("sequence level taken before filter time");
  AST_SEQ_HOLD: assert property (seq_raw == seq_filtered |=> $stable(seq_filtered))
    else $error("filtered level moved without cause");
  AST_APB_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("bus answer not in second access cycle");
endmodule // feedback_checker

bind feedback_pulse_and_input_qualify
  feedback_checker #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (.*);

// ==== sim/host_model.sv ====
module host_model (
  // Clock
  input  wire logic                      pclk,
  // Formats the host is set to
  input  wire feedback_pkg::pulse_mode_t mode,
  input  wire logic                      neg,
  input  wire logic                      fb_neg,
  // Lines
  output feedback_pkg::cmd_lines_t       cmd,
  input  wire feedback_pkg::fb_lines_t   fb
);
  timeunit 1ns;
  timeprecision 1ps;
  import feedback_pkg::*;
  logic [1:0] q  = 2'h0;  // Quadrature phase
  logic       p1 = 1'b0;  // First pair, plain level
  logic       p2 = 1'b0;  // Second pair, plain level
  logic       la = 1'b0;  // Last feedback A
  logic       lb = 1'b0;  // Last feedback B
  int         ra = 0;     // Feedback A rises
  int         rb = 0;     // Feedback B rises
  int         tq = 0;     // Feedback A and B edges
  wire logic  ua = fb.feedback_phase_a_pos ^ fb_neg;  // Host view of A
  wire logic  ub = fb.feedback_phase_b_pos ^ fb_neg;  // Host view of B
  // Legs always opposite; polarity applied to the plain level
  always_comb begin
    cmd.cmd_train_fwd_line        = ((mode == PM_QUAD) ? q[1] ^ q[0] : p1) ^ neg;
    cmd.cmd_train_fwd_line_neg    = !cmd.cmd_train_fwd_line;
    cmd.cmd_train_second_line     = ((mode == PM_QUAD) ? q[1] : p2) ^ neg;
    cmd.cmd_train_second_line_neg = !cmd.cmd_train_second_line;
  end
  // Host counter, undoing its own polarity setting
  always @(posedge pclk) begin
    ra += int'(ua && !la);
    rb += int'(ub && !lb);
    tq += int'(ua != la) + int'(ub != lb);
    la = ua;
    lb = ub;
  end
  // One step; 6-cycle levels give 19 cycles per step, faster than the 500 kpps top rate
  task automatic step(input logic rev);
    @(posedge pclk);
    if (mode == PM_QUAD) q <= rev ? q - 2'h1 : q + 2'h1;
    else p2 <= (mode == PM_PULSE_DIR) && rev;
    repeat (6) @(posedge pclk);
    if (mode == PM_FWD_REV && rev) p2 <= 1'b1;
    else if (mode != PM_QUAD) p1 <= 1'b1;
    repeat (6) @(posedge pclk);
    p1 <= 1'b0;
    if (mode == PM_FWD_REV) p2 <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule // host_model

// ==== sim/feedback_pulse_and_input_qualify_bench.sv ====
module feedback_pulse_and_input_qualify_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import feedback_pkg::*;
  localparam logic [16:0] FC = 17'd8;  // Short filter keeps holds brief
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, sp_o, sn_o, fs;
  logic        fstop = 0, cn = 0, fn = 0;
  logic [1:0]  ep = '0;
  logic [3:0]  seq = '0, sf;
  pulse_mode_t cm = PM_QUAD;
  cmd_lines_t  cmd;
  fb_lines_t   fb;
  enc_lines_t  enc = '0;
  int          n_mismatch = 0, comparisons = 0, sp = 0, sn = 0, a0, b0, t0, s0;
  always #20 pclk = ~pclk;
  // Step pulses stand one cycle, so count at every edge
  always @(posedge pclk) begin
    sp += int'(sp_o);
    sn += int'(sn_o);
  end
  feedback_pulse_and_input_qualify #(.FILTER_CYCLES(FC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_lines(cmd), .external_forced_stop(fstop), .seq_raw(seq), .fb_lines(fb), .enc(enc),
    .actuator_step_pos(sp_o), .actuator_step_neg(sn_o), .forced_stop(fs), .seq_filtered(sf)
  );
  host_model u_host (.pclk(pclk), .mode(cm), .neg(cn), .fb_neg(fn), .cmd(cmd), .fb(fb));
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    comparisons++;
    if (got !== ex) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (n >= 16) begin
      n_mismatch++;
      results();
    end
  endtask
  // One encoder step, A leading B going forward
  task enc_step(input logic rev);
    @(posedge pclk);
    ep = rev ? ep - 2'h1 : ep + 2'h1;
    enc <= {ep[1] ^ ep[0], ep[1]};
    repeat (60) @(posedge pclk);
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("fb_reset", 32'h16, 32'(fb));
    for (int i = 0; i < 3; i++) begin
      apb(0, 8'(4 * i), '0);
      chk("reg_reset", i == 0 ? 32'h0 : (i == 1 ? GEAR_RESET : 32'h800), rd);
    end
    apb(0, 8'h20, '0);
    chk("unmapped", 32'h1, 32'(er));
    apb(1, ADDR_STATUS, '1);
    chk("ro_write", 32'h0, 32'(er));
    $display("test registers done");
    // Every format and polarity; folded flips along with polarity
    for (int m = 0; m < 3; m++) begin
      for (int n = 0; n < 2; n++) begin
        cm <= pulse_mode_t'(m);
        cn <= n[0];
        apb(1, ADDR_CTRL, 32'(n * 96 + m * 8));
        repeat (20) @(posedge pclk);
        s0 = sn;
        a0 = sp;
        repeat (3) u_host.step(0);
        repeat (2) u_host.step(1);
        repeat (10) @(posedge pclk);
        chk("step_neg", n ? 2 : 3, sn - s0);
        chk("step_pos", n ? 3 : 2, sp - a0);
      end
    end
    $display("test command done");
    apb(1, ADDR_INDEX, 32'h4);
    for (int m = 0; m < 3; m++) begin
      for (int n = 0; n < 2; n++) begin
        fn <= n[0];
        apb(1, ADDR_CTRL, 32'(n * 4 + m));
        repeat (80) @(posedge pclk);
        a0 = u_host.ra;
        b0 = u_host.rb;
        t0 = u_host.tq;
        enc_step(0);
        chk("index_mid", n, 32'(fb.feedback_index_pos));
        enc_step(0);
        enc_step(1);
        enc_step(1);
        chk("fb_count", m == 2 ? 2 : 4, m == 0 ? u_host.tq - t0 : u_host.ra - a0);
        if (m == 2) chk("fb_rev", 2, u_host.rb - b0);
        if (m == 1) chk("fb_dir", 1, 32'(fb.feedback_phase_b_pos ^ n[0]));
        chk("index_end", !n, 32'(fb.feedback_index_pos));
      end
    end
    $display("test feedback done");
    cm <= PM_PULSE_DIR;
    cn <= 1'b0;
    fn <= 1'b0;
    apb(1, ADDR_GEAR, 32'h0001_0002);
    apb(1, ADDR_CTRL, 32'h09);
    repeat (80) @(posedge pclk);
    s0 = sn;
    a0 = u_host.ra;
    repeat (3) u_host.step(0);
    repeat (4) enc_step(0);
    chk("gear_cmd", 6, sn - s0);
    chk("gear_fb", 2, u_host.ra - a0);
    apb(0, ADDR_FBPOS, '0);
    chk("fb_pos", 2, rd);
    $display("test gear done");
    seq <= 4'hf;
    repeat (5) @(posedge pclk);
    seq <= 4'h0;
    repeat (20) @(posedge pclk);
    chk("seq_glitch", 32'h0, 32'(sf));
    seq <= 4'ha;
    repeat (12) @(posedge pclk);
    chk("seq_held", 32'ha, 32'(sf));
    fstop <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("fstop", 32'h1, 32'(fs));
    apb(0, ADDR_STATUS, '0);
    chk("status", 32'h1a, 32'(rd[4:0]));
    fstop <= 1'b0;
    $display("test inputs done");
    results();
  end
endmodule // feedback_pulse_and_input_qualify_bench
